// File: core/scs_params.svh
// constants for the scan sequencer: offsets, fields, resets and timing
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// register byte offsets
`define SCS_OFF_CTRL      12'h000
`define SCS_OFF_CHAN      12'h004
`define SCS_OFF_NORM_IVL  12'h008
`define SCS_OFF_ACQ_IVL   12'h00C
`define SCS_OFF_WEIGHT    12'h010
`define SCS_OFF_STATUS    12'h014
`define SCS_OFF_MIN_IVL   12'h018
`define SCS_OFF_COUNT     12'h01C

// control register fields
`define SCS_CTRL_VARB     0
`define SCS_CTRL_LINE50   1
`define SCS_CTRL_REARM    2
`define SCS_CTRL_OVR_CLR  3
// channel register fields
`define SCS_CHAN_SET      16
// status register fields
`define SCS_ST_LOCKED     2
`define SCS_ST_BUSY       3
`define SCS_ST_OVR        4
// count register field position of block count
`define SCS_CNT_BLK_LSB   16

// reset values
`define SCS_RST_CTRL      2'h0
`define SCS_RST_WEIGHT    8'h20
`define SCS_RST_IVL       22'h00_0000

// capacity
`define SCS_MAX_CH_A      10'd992
`define SCS_MAX_CH_B      10'd744
`define SCS_NUM_BLOCKS    248
`define SCS_NUM_SLOTS     31

// timing: base tick is one thirty-second of a line cycle
`define SCS_CLK_NS        25
`define SCS_TICK60_NS     520830
`define SCS_TICK50_NS     625000
`define SCS_TICKS_LINE    20'h0_0020
`define SCS_TENTH_T60     8'hC0
`define SCS_TENTH_T50     8'hA0
`define SCS_WEIGHT_PAD    9'h00C
`define SCS_MAX_TENTHS    22'h36_61E0

`endif

// File: core/scs_pkg.sv
// types shared by the scan sequencer modules
package scs_pkg;
	typedef enum logic [1:0] {SCS_PRE, SCS_ACQ, SCS_POST} scs_region_e;
	typedef enum logic [1:0] {SCS_WK_IDLE, SCS_WK_SCAN, SCS_WK_WAIT} scs_walk_e;
	typedef logic [9:0] scs_chan_t;
endpackage

// File: core/scs_chan_map.sv
// channel configuration bitmap with block and channel occupancy counts
`timescale 1ns/1ps
`default_nettype none
`include "scs_params.svh"
module scs_chan_map
	import scs_pkg::*;
#(
	parameter int NBLK = `SCS_NUM_BLOCKS
) (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// configuration update, index is channel number minus one
	input  wire logic       wr_en,
	input  wire logic       wr_set,
	input  wire scs_chan_t  wr_idx,
	// walker lookup
	input  wire scs_chan_t  rd_idx,
	output logic            rd_hit,
	// occupancy
	output scs_chan_t       chan_cnt,
	output logic [7:0]      blk_cnt
);
	logic [3:0] cfg_r [NBLK];   // one nibble per four-channel block
	scs_chan_t  chan_cnt_r;     // configured channels
	scs_chan_t  chan_cnt_nxt;
	logic [7:0] blk_cnt_r;      // non-empty blocks
	logic [7:0] blk_cnt_nxt;
	logic [3:0] old_w;          // addressed block before write
	logic [3:0] new_w;          // addressed block after write

	// counts follow each single write, so no full rescan is needed
	always_comb begin
		old_w = cfg_r[wr_idx[9:2]];
		new_w = old_w;
		new_w[wr_idx[1:0]] = wr_set;
		chan_cnt_nxt = chan_cnt_r;
		blk_cnt_nxt = blk_cnt_r;
		if (wr_en && (old_w != new_w)) begin
			if (wr_set) begin
				chan_cnt_nxt = chan_cnt_r + 10'h001;
			end else begin
				chan_cnt_nxt = chan_cnt_r - 10'h001;
			end
			// block turns occupied or empty
			if (old_w == 4'h0) begin
				blk_cnt_nxt = blk_cnt_r + 8'h01;
			end else if (new_w == 4'h0) begin
				blk_cnt_nxt = blk_cnt_r - 8'h01;
			end
		end
	end

	// bitmap and counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NBLK; i++) begin
				cfg_r[i] <= 4'h0;
			end
			chan_cnt_r <= 10'h000;
			blk_cnt_r <= 8'h00;
		end else begin
			if (wr_en) begin
				cfg_r[wr_idx[9:2]] <= new_w;
			end
			chan_cnt_r <= chan_cnt_nxt;
			blk_cnt_r <= blk_cnt_nxt;
		end
	end

	assign rd_hit = cfg_r[rd_idx[9:2]][rd_idx[1:0]];
	assign chan_cnt = chan_cnt_r;
	assign blk_cnt = blk_cnt_r;
endmodule
`default_nettype wire

// File: core/scs_pacer.sv
// line-locked time base: minimum-interval pulse and paced scan pulse
`timescale 1ns/1ps
`default_nettype none
`include "scs_params.svh"
module scs_pacer
	import scs_pkg::*;
#(
	parameter int TICK60_CYC = 20834,
	parameter int TICK50_CYC = 25000
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// configuration
	input  wire logic        line50,
	input  wire logic [19:0] min_ticks,
	input  wire logic [31:0] prog_ticks,
	// pulses
	output logic             min_pulse,
	output logic             scan_due
);
	localparam logic [15:0] P60 = 16'(TICK60_CYC - 1);
	localparam logic [15:0] P50 = 16'(TICK50_CYC - 1);

	logic [15:0] pre_r;       // clock prescaler to base tick
	logic [15:0] pre_nxt;
	logic [19:0] min_r;       // base ticks into minimum interval
	logic [19:0] min_nxt;
	logic [31:0] el_r;        // base ticks since last paced scan
	logic [31:0] el_nxt;
	logic        mp_r;
	logic        mp_nxt;
	logic        due_r;
	logic        due_nxt;
	logic        base;
	logic [31:0] target;

	// paced scans land on minimum-interval boundaries, so a programmed
	// interval rounds up to a whole number of minimum intervals
	always_comb begin
		base = (pre_r == (line50 ? P50 : P60));
		pre_nxt = base ? 16'h0000 : pre_r + 16'h0001;
		min_nxt = min_r;
		el_nxt = el_r;
		mp_nxt = 1'b0;
		due_nxt = 1'b0;
		if (prog_ticks == 32'h0000_0000) begin
			target = {12'h000, min_ticks};
		end else if (prog_ticks < {12'h000, min_ticks}) begin
			target = {12'h000, min_ticks};
		end else begin
			target = prog_ticks;
		end
		if (base) begin
			if (el_r != 32'hFFFF_FFFF) begin
				el_nxt = el_r + 32'h0000_0001;
			end
			if (min_r + 20'h0_0001 >= min_ticks) begin
				mp_nxt = 1'b1;
				min_nxt = 20'h0_0000;
			end else begin
				min_nxt = min_r + 20'h0_0001;
			end
		end
		if (mp_nxt && (el_nxt >= target)) begin
			due_nxt = 1'b1;
			el_nxt = 32'h0000_0000;
		end
	end

	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_r <= 16'h0000;
			min_r <= 20'h0_0000;
			el_r <= 32'h0000_0000;
			mp_r <= 1'b0;
			due_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			min_r <= min_nxt;
			el_r <= el_nxt;
			mp_r <= mp_nxt;
			due_r <= due_nxt;
		end
	end

	assign min_pulse = mp_r;
	assign scan_due = due_r;
endmodule
`default_nettype wire

// File: core/scs_top.sv
// scan sequencer top: apb registers, trigger regions and channel walker
// Operation
// - walk configured channels in ascending order
// - up to 992 or 744 channels, 31 slots
// - only configured channels measured and delivered
// - one channel set feeds registers and buffer
// - step sequentially, never random access
// - intervals from 99 hours to minimum
// - normal interval before start, after stop
// - acquisition interval between start and stop
// - two intervals: normal then acquisition
// - zero interval selects fast mode
// - both intervals always readable back
// - peak registers refresh every minimum interval
// - blocks of four consecutive channels
// - first variant minimum from occupied blocks
// - track up to 248 blocks
// - second variant ignores channel grouping
// - ceil(blocks/4) times one line cycle
// - channels times (weight+12) times sample
// - refuse configuration while armed or acquiring
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "scs_params.svh"
module scs_top
	import scs_pkg::*;
#(
	parameter int TICK60_CYC =
		(`SCS_TICK60_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS,
	parameter int TICK50_CYC =
		(`SCS_TICK50_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// trigger logic
	input  wire logic        trig_armed,
	input  wire logic        trig_start,
	input  wire logic        trig_stop,
	// measurement path
	output logic             meas_valid,
	output scs_chan_t        meas_chan,
	output logic             meas_to_buf,
	input  wire logic        meas_ready,
	// scan markers
	output logic             hll_tick,
	output logic             buf_scan
);
	// minimum interval in base ticks for the present configuration
	function automatic logic [19:0] min_ticks_f(
		input logic       var_b,
		input logic [7:0] blks,
		input scs_chan_t  chans,
		input logic [7:0] wt
	);
		logic [7:0]  s;
		logic [8:0]  wp;
		logic [19:0] r;
		s = blks + 8'h03;
		wp = {1'b0, wt} + `SCS_WEIGHT_PAD;
		if (var_b) begin
			r = {10'h000, chans} * {11'h000, wp};
		end else begin
			r = {9'h000, s[7:2], 5'h00};
		end
		// an empty scan still keeps one line cycle of pace
		if (r == 20'h0_0000) begin
			r = `SCS_TICKS_LINE;
		end
		return r;
	endfunction

	// register state
	logic [1:0]  ctrl_r;         // variant and line frequency
	logic [1:0]  ctrl_nxt;
	logic [21:0] norm_r;         // normal interval, tenths of a second
	logic [21:0] norm_nxt;
	logic [21:0] acq_r;          // acquisition interval, tenths
	logic [21:0] acq_nxt;
	logic [7:0]  wt_r;           // samples per channel
	logic [7:0]  wt_nxt;
	logic        ovr_r;          // walk still busy when next one due
	logic        ovr_nxt;
	logic [19:0] minv_r;         // registered minimum interval
	logic [19:0] minv_nxt;
	// apb state
	logic        pready_r;
	logic        pready_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        perr_r;
	logic        perr_nxt;
	logic        wok_r;          // write accepted at setup
	logic        wok_nxt;
	// region state
	scs_region_e reg_r;
	scs_region_e reg_nxt;
	// walker state
	scs_walk_e   wk_r;
	scs_walk_e   wk_nxt;
	scs_chan_t   idx_r;          // channel index being examined
	scs_chan_t   idx_nxt;
	logic        mv_r;
	logic        mv_nxt;
	scs_chan_t   mc_r;
	scs_chan_t   mc_nxt;
	logic        mb_r;           // current walk goes to the buffer
	logic        mb_nxt;
	logic        hll_r;
	logic        hll_nxt;
	logic        bs_r;
	logic        bs_nxt;
	// glue
	logic        setup;
	logic        commit;
	logic        locked;
	logic        chan_wr;
	logic        rd_hit;
	scs_chan_t   chan_cnt;
	logic [7:0]  blk_cnt;
	logic        min_pulse;
	logic        scan_due;
	logic [31:0] prog_ticks;
	logic [7:0]  tenth_t;
	logic [21:0] sel_ivl;
	scs_chan_t   max_ch;
	scs_chan_t   wr_ch;
	logic        addr_ok;
	logic        val_ok;
	logic [31:0] rd_val;

	// combinational glue shared by the register and walker processes
	always_comb begin
		setup = psel && !penable && !pready_r;
		commit = psel && penable && pready_r && pwrite && wok_r;
		locked = trig_armed || (reg_r == SCS_ACQ);
		max_ch = ctrl_r[`SCS_CTRL_VARB] ? `SCS_MAX_CH_B
			: `SCS_MAX_CH_A;
		wr_ch = pwdata[9:0] - 10'h001;
		chan_wr = commit && (paddr == `SCS_OFF_CHAN);
		tenth_t = ctrl_r[`SCS_CTRL_LINE50] ? `SCS_TENTH_T50
			: `SCS_TENTH_T60;
		// region picks which interval paces buffered scans
		sel_ivl = (reg_r == SCS_ACQ) ? acq_r : norm_r;
		prog_ticks = {10'h000, sel_ivl} * {24'h00_0000, tenth_t};
	end

	// address decode, write legality and read mux
	always_comb begin
		addr_ok = 1'b1;
		val_ok = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			`SCS_OFF_CTRL: rd_val = {30'h0000_0000, ctrl_r};
			`SCS_OFF_CHAN: begin
				// channel numbers run from one to the variant limit
				val_ok = !locked && (pwdata[9:0] != 10'h000)
					&& (pwdata[9:0] <= max_ch);
			end
			`SCS_OFF_NORM_IVL: begin
				rd_val = {10'h000, norm_r};
				val_ok = pwdata[21:0] <= `SCS_MAX_TENTHS;
			end
			`SCS_OFF_ACQ_IVL: begin
				rd_val = {10'h000, acq_r};
				val_ok = pwdata[21:0] <= `SCS_MAX_TENTHS;
			end
			`SCS_OFF_WEIGHT: begin
				rd_val = {24'h00_0000, wt_r};
				val_ok = !locked;
			end
			`SCS_OFF_STATUS: begin
				rd_val = {27'h000_0000, ovr_r, (wk_r != SCS_WK_IDLE),
					locked, reg_r};
				val_ok = 1'b0;
			end
			`SCS_OFF_MIN_IVL: begin
				rd_val = {12'h000, minv_r};
				val_ok = 1'b0;
			end
			`SCS_OFF_COUNT: begin
				rd_val = {8'h00, blk_cnt, 6'h00, chan_cnt};
				val_ok = 1'b0;
			end
			default: addr_ok = 1'b0;
		endcase
	end

	// apb handshake: no wait states, pready in the first access cycle, answer decided in the setup cycle
	always_comb begin
		pready_nxt = setup;
		prdata_nxt = (setup && !pwrite) ? rd_val : 32'h0000_0000;
		perr_nxt = setup && (!addr_ok || (pwrite && !val_ok));
		wok_nxt = setup ? (addr_ok && val_ok) : wok_r;
	end

	// software registers
	always_comb begin
		ctrl_nxt = ctrl_r;
		norm_nxt = norm_r;
		acq_nxt = acq_r;
		wt_nxt = wt_r;
		ovr_nxt = ovr_r;
		if (commit) begin
			case (paddr)
				`SCS_OFF_CTRL: begin
					// variant and line change only when unlocked
					if (!locked) begin
						ctrl_nxt = pwdata[1:0];
					end
					if (pwdata[`SCS_CTRL_OVR_CLR]) begin
						ovr_nxt = 1'b0;
					end
				end
				`SCS_OFF_NORM_IVL: norm_nxt = pwdata[21:0];
				`SCS_OFF_ACQ_IVL: acq_nxt = pwdata[21:0];
				`SCS_OFF_WEIGHT: wt_nxt = pwdata[7:0];
				default: ;
			endcase
		end
		// a new overrun wins over a clear in the same cycle
		if (min_pulse && (wk_r != SCS_WK_IDLE)) begin
			ovr_nxt = 1'b1;
		end
		// recomputed every cycle from live counts, variant choice and weight
		minv_nxt = min_ticks_f(ctrl_r[`SCS_CTRL_VARB], blk_cnt,
			chan_cnt, wt_r);
	end

	// trigger regions
	always_comb begin
		reg_nxt = reg_r;
		case (reg_r)
			SCS_PRE: if (trig_start) reg_nxt = SCS_ACQ;
			SCS_ACQ: if (trig_stop) reg_nxt = SCS_POST;
			SCS_POST: begin
				if (commit && (paddr == `SCS_OFF_CTRL)
					&& pwdata[`SCS_CTRL_REARM]) begin
					reg_nxt = SCS_PRE;
				end
			end
			default: reg_nxt = SCS_PRE;
		endcase
	end

	// channel walker: each minimum interval that finds it idle starts one ascending pass
	always_comb begin
		wk_nxt = wk_r;
		idx_nxt = idx_r;
		mv_nxt = mv_r;
		mc_nxt = mc_r;
		mb_nxt = mb_r;
		hll_nxt = 1'b0;
		bs_nxt = 1'b0;
		case (wk_r)
			SCS_WK_IDLE: begin
				if (min_pulse) begin
					wk_nxt = SCS_WK_SCAN;
					idx_nxt = 10'h000;
					mb_nxt = scan_due;
					hll_nxt = 1'b1;
					bs_nxt = scan_due;
				end
			end
			SCS_WK_SCAN: begin
				if (idx_r >= max_ch) begin
					wk_nxt = SCS_WK_IDLE;
				end else if (rd_hit) begin
					mv_nxt = 1'b1;
					mc_nxt = idx_r + 10'h001;
					wk_nxt = SCS_WK_WAIT;
				end else begin
					idx_nxt = idx_r + 10'h001;
				end
			end
			SCS_WK_WAIT: begin
				if (meas_ready) begin
					mv_nxt = 1'b0;
					idx_nxt = idx_r + 10'h001;
					wk_nxt = SCS_WK_SCAN;
				end
			end
			default: wk_nxt = SCS_WK_IDLE;
		endcase
	end

	// all state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `SCS_RST_CTRL;
			norm_r <= `SCS_RST_IVL;
			acq_r <= `SCS_RST_IVL;
			wt_r <= `SCS_RST_WEIGHT;
			ovr_r <= 1'b0;
			minv_r <= `SCS_TICKS_LINE;
			pready_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			perr_r <= 1'b0;
			wok_r <= 1'b0;
			reg_r <= SCS_PRE;
			wk_r <= SCS_WK_IDLE;
			idx_r <= 10'h000;
			mv_r <= 1'b0;
			mc_r <= 10'h000;
			mb_r <= 1'b0;
			hll_r <= 1'b0;
			bs_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			norm_r <= norm_nxt;
			acq_r <= acq_nxt;
			wt_r <= wt_nxt;
			ovr_r <= ovr_nxt;
			minv_r <= minv_nxt;
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			perr_r <= perr_nxt;
			wok_r <= wok_nxt;
			reg_r <= reg_nxt;
			wk_r <= wk_nxt;
			idx_r <= idx_nxt;
			mv_r <= mv_nxt;
			mc_r <= mc_nxt;
			mb_r <= mb_nxt;
			hll_r <= hll_nxt;
			bs_r <= bs_nxt;
		end
	end

	// configuration store
	scs_chan_map u_map (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_en    (chan_wr),
		.wr_set   (pwdata[`SCS_CHAN_SET]),
		.wr_idx   (wr_ch),
		.rd_idx   (idx_r),
		.rd_hit   (rd_hit),
		.chan_cnt (chan_cnt),
		.blk_cnt  (blk_cnt)
	);

	// time base
	scs_pacer #(
		.TICK60_CYC (TICK60_CYC),
		.TICK50_CYC (TICK50_CYC)
	) u_pacer (
		.pclk       (pclk),
		.presetn    (presetn),
		.line50     (ctrl_r[`SCS_CTRL_LINE50]),
		.min_ticks  (minv_r),
		.prog_ticks (prog_ticks),
		.min_pulse  (min_pulse),
		.scan_due   (scan_due)
	);

	// outputs straight from flops
	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = perr_r;
	assign meas_valid = mv_r;
	assign meas_chan = mc_r;
	assign meas_to_buf = mb_r;
	assign hll_tick = hll_r;
	assign buf_scan = bs_r;
endmodule
`default_nettype wire

// File: verif/scs_top_checker.sv
// port assertions for the scan sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "scs_params.svh"
module scs_top_checker
	import scs_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        trig_armed,
	// measurement path and markers
	input wire logic        meas_valid,
	input wire scs_chan_t   meas_chan,
	input wire logic        meas_to_buf,
	input wire logic        meas_ready,
	input wire logic        hll_tick,
	input wire logic        buf_scan
);
	scs_chan_t last_r; // last accepted channel of this walk
	logic      tob_r;  // buffer flag latched at walk start
	wire       acc = meas_valid && meas_ready; // channel handed over
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// track walk start and accepted channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r <= '0;
			tob_r  <= 1'b0;
		end else if (hll_tick) begin
			last_r <= '0;
			tob_r  <= buf_scan;
		end else if (acc) begin
			last_r <= meas_chan;
		end
	end
	// apb setup cycle
	sequence s_setup;
		psel && !penable;
	endsequence
	// channel write set up and accessed while armed
	sequence s_chan_armed;
		psel && !penable && pwrite && paddr == `SCS_OFF_CHAN && trig_armed
			##1 trig_armed;
	endsequence
	// accepted request then a quiet cycle
	sequence s_accept_gap;
		acc ##1 !meas_valid;
	endsequence
	AST_READY_ONE_WAIT: assert property (s_setup |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");
	AST_PRDATA_IDLE: assert property (!pready |-> prdata == '0)
		else $error("prdata nonzero outside access");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_CHAN_LOCKED: assert property (s_chan_armed |-> pslverr)
		else $error("channel write accepted while armed");
	AST_RO_REFUSED: assert property (psel && !penable && pwrite &&
		paddr inside {`SCS_OFF_STATUS, `SCS_OFF_MIN_IVL, `SCS_OFF_COUNT}
		|=> pslverr)
		else $error("write to read-only register accepted");
	AST_MEAS_RANGE: assert property (meas_valid |->
		meas_chan inside {[10'h001:10'h3E0]})
		else $error("channel number out of range");
	AST_MEAS_HOLD: assert property (meas_valid && !meas_ready |=>
		meas_valid && $stable(meas_chan))
		else $error("request dropped or changed before accept");
	AST_REQ_GAP: assert property (acc |-> s_accept_gap)
		else $error("request right after accept");
	AST_ASCEND: assert property (meas_valid |-> meas_chan > last_r)
		else $error("channel not ascending in walk");
	AST_BUF_TICK: assert property (buf_scan |-> hll_tick)
		else $error("buffer scan marker without walk start");
	AST_TO_BUF: assert property (meas_valid |-> meas_to_buf == tob_r)
		else $error("buffer flag differs from walk marker");
	AST_TICK_PULSE: assert property (hll_tick |=> !hll_tick [*8])
		else $error("walk starts too close together");
endmodule
bind scs_top scs_top_checker chk_i (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata,
	.pslverr, .trig_armed, .meas_valid, .meas_chan, .meas_to_buf,
	.meas_ready, .hll_tick, .buf_scan
);
`default_nettype wire

// File: verif/scs_conv_model.sv
// converter model: takes channel requests after a set delay
`timescale 1ns/1ps
`default_nettype none
module scs_conv_model
	import scs_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// channel request
	input  wire logic       meas_valid,
	input  wire scs_chan_t  meas_chan,
	output logic            meas_ready,
	// cycles to stall before accepting
	input  wire logic [3:0] dly
);
	scs_chan_t  got[$]; // accepted channels in order
	logic [3:0] cnt_r;  // stall count of the open request
	// ready pulses once per request, after the stall
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r      <= 4'h0;
			meas_ready <= 1'b0;
		end else if (meas_valid && !meas_ready && cnt_r >= dly) begin
			meas_ready <= 1'b1;
			cnt_r      <= 4'h0;
		end else begin
			meas_ready <= 1'b0;
			cnt_r      <= (meas_valid && !meas_ready) ? cnt_r + 4'h1 : 4'h0;
		end
	end
	// log only what was really handed over
	always @(posedge pclk)
		if (presetn && meas_valid && meas_ready)
			got.push_back(meas_chan);
endmodule
`default_nettype wire

// File: verif/tb_scs_top.sv
// self-checking bench for the scan sequencer top
`timescale 1ns/1ps
`default_nettype none
`include "scs_params.svh"
module tb_scs_top
	import scs_pkg::*;
;
	localparam int T60 = 40; // short base tick, 60 Hz
	localparam int T50 = 50; // short base tick, 50 Hz
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        trig_armed, trig_start, trig_stop, b;
	logic        meas_valid, meas_to_buf, meas_ready, hll_tick, buf_scan;
	scs_chan_t   meas_chan;
	logic [3:0]  dly;       // converter stall
	int          n_mismatch, checks_done, c;
	logic [31:0] ent[$] = '{101, 5, 1, 15, 100, 2, 7, 3, 4}; // entry order
	logic [31:0] srt[$];    // expected walk order
	scs_top #(.TICK60_CYC(T60), .TICK50_CYC(T50)) dut (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .trig_armed, .trig_start, .trig_stop, .meas_valid,
		.meas_chan, .meas_to_buf, .meas_ready, .hll_tick, .buf_scan);
	scs_conv_model conv (.pclk, .presetn, .meas_valid, .meas_chan,
		.meas_ready, .dly);
	// free-running clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// verdict and end of run
	task automatic complete_run;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one apb transfer, request held until pready is sampled high
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] e, input logic ee);
		int          n;
		logic [31:0] r;
		logic        er;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// right after the edge we still see what that edge sampled
		for (n = 0; n < 64; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		r  = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n == 64) begin
			n_mismatch++;
			complete_run();
		end
		if (!w)
			chk(r, e);
		chk({31'h0, er}, {31'h0, ee});
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic ee);
		acc(1'b1, a, d, 32'h0, ee);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0, e, 1'b0);
	endtask
	// cycles to the next walk start, with its buffer flag
	task automatic tick(output int cy, output logic bf);
		for (cy = 1; cy < 20000; cy++) begin
			@(negedge pclk);
			if (hll_tick === 1'b1)
				break;
		end
		bf = buf_scan;
		if (cy == 20000) begin
			n_mismatch++;
			complete_run();
		end
	endtask
	// cycles between two consecutive buffer scans after a change
	task automatic pgap(input int e);
		int   g, k, cy;
		logic bf;
		g = 0;
		k = 0;
		for (int n = 0; n < 12 && k < 2; n++) begin
			tick(cy, bf);
			if (k == 1)
				g += cy;
			if (bf === 1'b1)
				k++;
		end
		chk(g, e);
	endtask
	// pulse a trigger input for one edge
	task automatic pulse(input logic stop);
		@(posedge pclk);
		trig_start <= !stop;
		trig_stop  <= stop;
		@(posedge pclk);
		trig_start <= 1'b0;
		trig_stop  <= 1'b0;
	endtask
	// main sequence
	initial begin
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 12'h000;
		pwdata     = 32'h0;
		trig_armed = 1'b0;
		trig_start = 1'b0;
		trig_stop  = 1'b0;
		dly        = 4'h0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(`SCS_OFF_STATUS, 32'h0);
		rd(`SCS_OFF_WEIGHT, 32'h20);
		rd(`SCS_OFF_NORM_IVL, 32'h0);
		rd(`SCS_OFF_MIN_IVL, 32'h20);
		acc(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
		wr(`SCS_OFF_STATUS, 32'h0, 1'b1);
		// out-of-order entry, refused edges
		foreach (ent[i])
			wr(`SCS_OFF_CHAN, 32'h1_0000 | ent[i], 1'b0);
		wr(`SCS_OFF_CHAN, 32'h1_0000, 1'b1);
		wr(`SCS_OFF_CHAN, 32'h1_03E1, 1'b1);
		rd(`SCS_OFF_COUNT, 32'h5_0009);
		rd(`SCS_OFF_MIN_IVL, 32'h40);
		// one full walk with a stalling converter
		dly <= 4'h3;
		tick(c, b);
		conv.got.delete();
		tick(c, b);
		chk(c, 64 * T60);
		srt = ent;
		srt.sort();
		chk(conv.got.size(), srt.size());
		foreach (srt[i])
			chk({22'h0, conv.got[i]}, srt[i]);
		// last channel opens a sixth block
		wr(`SCS_OFF_CHAN, 32'h1_03E0, 1'b0);
		rd(`SCS_OFF_COUNT, 32'h6_000A);
		wr(`SCS_OFF_CHAN, 32'h0_03E0, 1'b0);
		rd(`SCS_OFF_COUNT, 32'h5_0009);
		trig_armed <= 1'b1;
		wr(`SCS_OFF_CHAN, 32'h1_0009, 1'b1);
		trig_armed <= 1'b0;
		rd(`SCS_OFF_COUNT, 32'h5_0009);
		// 50 Hz line stretches the minimum
		wr(`SCS_OFF_CTRL, 32'h2, 1'b0);
		tick(c, b);
		tick(c, b);
		chk(c, 64 * T50);
		wr(`SCS_OFF_CTRL, 32'h0, 1'b0);
		// intervals: limit, readback, regions
		dly <= 4'h0;
		wr(`SCS_OFF_NORM_IVL, 32'h1, 1'b0);
		wr(`SCS_OFF_ACQ_IVL, 32'h36_61E1, 1'b1);
		wr(`SCS_OFF_ACQ_IVL, 32'h36_61E0, 1'b0);
		rd(`SCS_OFF_ACQ_IVL, 32'h36_61E0);
		wr(`SCS_OFF_ACQ_IVL, 32'h0, 1'b0);
		rd(`SCS_OFF_NORM_IVL, 32'h1);
		pgap(192 * T60);
		pulse(1'b0);
		rd(`SCS_OFF_NORM_IVL, 32'h1);
		wr(`SCS_OFF_CHAN, 32'h1_0009, 1'b1);
		pgap(64 * T60);
		rd(`SCS_OFF_STATUS, 32'hD);
		pulse(1'b1);
		pgap(192 * T60);
		// second variant: weight formula, no grouping
		wr(`SCS_OFF_CTRL, 32'h1, 1'b0);
		rd(`SCS_OFF_MIN_IVL, 32'h18C);
		wr(`SCS_OFF_WEIGHT, 32'hA, 1'b0);
		rd(`SCS_OFF_MIN_IVL, 32'hC6);
		pgap(198 * T60);
		wr(`SCS_OFF_CHAN, 32'h1_02E9, 1'b1);
		wr(`SCS_OFF_CHAN, 32'h1_02E8, 1'b0);
		rd(`SCS_OFF_MIN_IVL, 32'hDC);
		// rearm back to the pre-trigger region, walk just started
		wr(`SCS_OFF_CTRL, 32'h5, 1'b0);
		tick(c, b);
		rd(`SCS_OFF_STATUS, 32'h8);
		complete_run();
	end
endmodule
`default_nettype wire
